//--- hdl/dpu_pkg.sv
package dpu_pkg;

  // ==========================================================
  // Clock and reference tick
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned REF_TICK_US = 1;
  localparam int unsigned REF_TICK_CYCLES = CLK_MHZ * REF_TICK_US;
  localparam int unsigned TICKS_PER_MS = 1000 / REF_TICK_US;
  localparam int unsigned TICKS_PER_MIN = 60000000 / REF_TICK_US;

  // ==========================================================
  // Sequence times in milliseconds
  localparam int unsigned SUPPLY_WAIT_MS = 3000;
  localparam int unsigned SPINUP_WAIT_MS = 5000;
  localparam int unsigned SPEED_GOOD_WAIT_MS = 60000;
  localparam int unsigned ACCEL_END_WAIT_MS = 50000;
  localparam int unsigned CMP_ACT_HOLD_MS = 400;
  localparam int unsigned CMP_BEGIN_HOLD_MS = 270;
  localparam int unsigned UNLOCK_DELAY_MS = 10;
  localparam int unsigned SEEK_WAIT_MS = 1000;

  // ==========================================================
  // Speed limits as revolution periods in reference ticks
  localparam int unsigned RPM_STOPPED = 45;
  localparam int unsigned RPM_TURNING = 12;
  localparam int unsigned RPM_WINDING = 1500;
  localparam int unsigned RPM_NOMINAL = 3620;
  localparam int unsigned SPEED_TOL_PCT = 6;
  localparam int unsigned PER_STOPPED = TICKS_PER_MIN / RPM_STOPPED;
  localparam int unsigned PER_TURNING = TICKS_PER_MIN / RPM_TURNING;
  localparam int unsigned PER_WINDING = TICKS_PER_MIN / RPM_WINDING;
  localparam int unsigned PER_NOMINAL = TICKS_PER_MIN / RPM_NOMINAL;
  localparam int unsigned PER_FAST_LIM = PER_NOMINAL * 100 / (100 + SPEED_TOL_PCT);
  localparam int unsigned PER_SLOW_LIM = PER_NOMINAL * 100 / (100 - SPEED_TOL_PCT);
  localparam int unsigned PER_WIDTH = 23;
  localparam int unsigned TMR_WIDTH = 27;

  // ==========================================================
  // Register map
  localparam logic [11:0] REG_SETTINGS = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_PERIOD = 12'h008;
  localparam logic [11:0] REG_CYL_LIMIT = 12'h00C;
  localparam logic [11:0] REG_WORKING = 12'h010;
  localparam logic [15:0] SETTINGS_RESET = 16'h0001;
  localparam logic [9:0] CYL_LIMIT_VALUE = 10'h2E9;
  localparam int unsigned SET_SPIN_ALLOW = 0;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_POWER = 4'h0,
    ST_SUPPLY = 4'h1,
    ST_LOAD = 4'h2,
    ST_UNLOCK = 4'h3,
    ST_SPINUP = 4'h4,
    ST_ACCEL = 4'h5,
    ST_SETTLE = 4'h6,
    ST_SEEK = 4'h7,
    ST_READY = 4'h8,
    ST_HALT = 4'h9
  } dpu_state_type;

  typedef enum logic [2:0] {
    FLT_NONE = 3'h0,
    FLT_SUPPLY = 3'h1,
    FLT_LOCK = 3'h2,
    FLT_SPIN = 3'h3,
    FLT_SPEED_GOOD = 3'h4,
    FLT_ACCEL = 3'h5,
    FLT_SEEK = 3'h6,
    FLT_DRIFT = 3'h7
  } dpu_fault_type;

  typedef struct packed {
    logic por;
    logic sup_24v;
    logic sup_neg12v;
    logic sup_pos12v;
    logic unlocked;
    logic cmp_act;
    logic cmp_begin;
    logic at_zero;
    logic [2:0] hall;
  } dpu_pins_type;

endpackage

//--- hdl/dpu_sequencer.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dpu_sequencer
  import dpu_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = REF_TICK_CYCLES,
  parameter int unsigned SUPPLY_WAIT_TICKS = SUPPLY_WAIT_MS * TICKS_PER_MS,
  parameter int unsigned SPINUP_WAIT_TICKS = SPINUP_WAIT_MS * TICKS_PER_MS,
  parameter int unsigned SPEED_GOOD_WAIT_TICKS = SPEED_GOOD_WAIT_MS * TICKS_PER_MS,
  parameter int unsigned ACCEL_END_WAIT_TICKS = ACCEL_END_WAIT_MS * TICKS_PER_MS,
  parameter int unsigned CMP_ACT_TICKS = CMP_ACT_HOLD_MS * TICKS_PER_MS,
  parameter int unsigned CMP_BEGIN_TICKS = CMP_BEGIN_HOLD_MS * TICKS_PER_MS,
  parameter int unsigned UNLOCK_DELAY_TICKS = UNLOCK_DELAY_MS * TICKS_PER_MS,
  parameter int unsigned SEEK_WAIT_TICKS = SEEK_WAIT_MS * TICKS_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_reset_ind,
  input wire logic supply_24v_good,
  input wire logic supply_neg12v_good,
  input wire logic supply_pos12v_good,
  input wire logic actuator_unlocked_status,
  input wire logic compress_active,
  input wire logic compress_begin,
  input wire logic seek_at_cylinder_zero,
  input wire logic hall_phase_a_n,
  input wire logic hall_phase_b,
  input wire logic hall_phase_c_n,
  output logic supply_ok,
  output logic emergency_head_retract,
  output logic actuator_lock_release,
  output logic start_winding_select,
  output logic spindle_accel_control,
  output logic spindle_accel_enable,
  output logic spindle_speed_ok,
  output logic start_complete,
  output logic compress_enable,
  output logic tach_pulse,
  output logic [2:0] winding_drive,
  output logic hall_fault,
  output logic osc_clock_out,
  output logic divided_clock_one,
  output logic divided_clock_two,
  output logic initial_seek_start,
  output logic servo_reset,
  output logic drive_ready
);

  // ==========================================================
  // Pin synchronisers
  dpu_pins_type pins_raw;
  dpu_pins_type pins_meta;
  dpu_pins_type pins_sync;
  logic [2:0] sync_fill;

  assign pins_raw = '{por: power_on_reset_ind, sup_24v: supply_24v_good,
                      sup_neg12v: supply_neg12v_good, sup_pos12v: supply_pos12v_good,
                      unlocked: actuator_unlocked_status, cmp_act: compress_active,
                      cmp_begin: compress_begin, at_zero: seek_at_cylinder_zero,
                      hall: {~hall_phase_c_n, hall_phase_b, ~hall_phase_a_n}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta <= '0;
      pins_sync <= '0;
      sync_fill <= 3'h0;
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
      sync_fill <= {sync_fill[1:0], 1'b1};
    end
  end

  // ==========================================================
  // Reference tick and clock outputs
  logic [15:0] tick_cnt;
  logic tick;
  logic [3:0] clk_div;
  wire tick_wrap = (tick_cnt == 16'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
      clk_div <= 4'h0;
      osc_clock_out <= 1'b0;
      divided_clock_one <= 1'b0;
      divided_clock_two <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? 16'h0000 : tick_cnt + 16'h0001;
      tick <= tick_wrap;
      clk_div <= clk_div + 4'h1;
      osc_clock_out <= ~osc_clock_out;
      divided_clock_one <= clk_div[1];
      divided_clock_two <= clk_div[3];
    end
  end

  // ==========================================================
  // Hall division by three and revolution periods
  localparam logic [PER_WIDTH-1:0] PER_MAX = '1;
  logic [2:0] rev_pulse;
  logic [PER_WIDTH-1:0] eff_period [3];
  logic [PER_WIDTH-1:0] last_period [3];

  for (genvar i = 0; i < 3; i++) begin : g_phase
    logic prev;
    logic [1:0] div3;
    logic pulse;
    logic [PER_WIDTH-1:0] run;
    logic [PER_WIDTH-1:0] period;
    // Edges held off until prev holds a real sample; a high pin is no edge
    wire rise = pins_sync.hall[i] & ~prev & sync_fill[2];
    wire wrap = rise & (div3 == 2'h2);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev <= 1'b0;
        div3 <= 2'h0;
        pulse <= 1'b0;
        run <= '0;
        period <= PER_MAX;
      end else begin
        prev <= pins_sync.hall[i];
        pulse <= wrap;
        if (rise) begin
          div3 <= wrap ? 2'h0 : div3 + 2'h1;
        end
        if (wrap) begin
          period <= run;
          run <= '0;
        end else if (tick && run != PER_MAX) begin
          run <= run + 1'b1;
        end
      end
    end
    // A stalled motor shows up as a growing period, not a stale one
    assign eff_period[i] = (run > period) ? run : period;
    assign last_period[i] = period;
    assign rev_pulse[i] = pulse;
  end

  wire [PER_WIDTH-1:0] speed_per = eff_period[1];
  wire spin_stopped = speed_per >= PER_WIDTH'(PER_STOPPED);
  wire spin_turning = speed_per <= PER_WIDTH'(PER_TURNING);
  wire spin_main = speed_per <= PER_WIDTH'(PER_WINDING);
  wire speed_good_now = (speed_per >= PER_WIDTH'(PER_FAST_LIM)) &&
                        (speed_per <= PER_WIDTH'(PER_SLOW_LIM));
  wire accel_req_now = eff_period[2] > PER_WIDTH'(PER_NOMINAL);

  // Commutation code from the conditioned phases
  wire [2:0] hall_code = pins_sync.hall;
  wire hall_bad = (hall_code == 3'h0) || (hall_code == 3'h7);
  wire [2:0] next_winding = (hall_code == 3'h1 || hall_code == 3'h6) ? 3'h1 :
                            (hall_code == 3'h2 || hall_code == 3'h5) ? 3'h2 :
                            (hall_code == 3'h3 || hall_code == 3'h4) ? 3'h4 : 3'h0;

  // ==========================================================
  // Sequencer state
  dpu_state_type state;
  dpu_state_type next_state;
  dpu_fault_type fault;
  dpu_fault_type next_fault;
  logic [TMR_WIDTH-1:0] state_timer;
  logic [TMR_WIDTH-1:0] motor_timer;
  logic [TMR_WIDTH-1:0] cmp_act_cnt;
  logic [TMR_WIDTH-1:0] cmp_begin_cnt;
  logic [15:0] nv_settings;
  logic [15:0] working;
  logic [9:0] cyl_limit;
  logic spindle_accel_request;

  wire supply_now = pins_sync.por & pins_sync.sup_24v & pins_sync.sup_neg12v &
                    pins_sync.sup_pos12v;
  wire motor_go = spindle_accel_request & working[SET_SPIN_ALLOW];
  wire drifted = ~spindle_speed_ok;

  always_comb begin
    next_state = state;
    next_fault = fault;
    unique case (state)
      ST_POWER: begin
        if (pins_sync.por) begin
          next_state = ST_SUPPLY;
        end
      end
      ST_SUPPLY: begin
        if (supply_ok && spin_stopped) begin
          next_state = ST_LOAD;
        end else if (!supply_ok && state_timer >= TMR_WIDTH'(SUPPLY_WAIT_TICKS)) begin
          next_state = ST_HALT;
          next_fault = FLT_SUPPLY;
        end
      end
      ST_LOAD: begin
        next_state = ST_UNLOCK;
      end
      ST_UNLOCK: begin
        if (state_timer >= TMR_WIDTH'(UNLOCK_DELAY_TICKS)) begin
          next_state = pins_sync.unlocked ? ST_HALT : ST_SPINUP;
          next_fault = pins_sync.unlocked ? FLT_LOCK : fault;
        end
      end
      ST_SPINUP: begin
        if (spindle_accel_control && spin_turning) begin
          next_state = ST_ACCEL;
        end else if (spindle_accel_control &&
                     motor_timer >= TMR_WIDTH'(SPINUP_WAIT_TICKS)) begin
          next_state = ST_HALT;
          next_fault = FLT_SPIN;
        end
      end
      ST_ACCEL: begin
        if (spindle_speed_ok) begin
          next_state = ST_SETTLE;
        end else if (motor_timer >= TMR_WIDTH'(SPEED_GOOD_WAIT_TICKS)) begin
          next_state = ST_HALT;
          next_fault = FLT_SPEED_GOOD;
        end
      end
      ST_SETTLE: begin
        if (!spindle_accel_request) begin
          next_state = ST_SEEK;
        end else if (state_timer >= TMR_WIDTH'(ACCEL_END_WAIT_TICKS)) begin
          next_state = ST_HALT;
          next_fault = FLT_ACCEL;
        end
      end
      ST_SEEK: begin
        if (drifted) begin
          next_state = ST_HALT;
          next_fault = FLT_DRIFT;
        end else if (pins_sync.at_zero && state_timer != '0) begin
          next_state = ST_READY;
        end else if (state_timer >= TMR_WIDTH'(SEEK_WAIT_TICKS)) begin
          next_state = ST_HALT;
          next_fault = FLT_SEEK;
        end
      end
      ST_READY: begin
        if (drifted) begin
          next_state = ST_HALT;
          next_fault = FLT_DRIFT;
        end
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
    // Losing the power indication is a power cycle from any state
    if (!pins_sync.por) begin
      next_state = ST_POWER;
      next_fault = FLT_NONE;
    end
  end

  wire state_change = (next_state != state);
  wire in_flight = (state == ST_SEEK) || (state == ST_READY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_POWER;
      fault <= FLT_NONE;
      state_timer <= '0;
      motor_timer <= '0;
    end else begin
      state <= next_state;
      fault <= next_fault;
      state_timer <= state_change ? '0 : (tick && state_timer != '1) ?
                     state_timer + 1'b1 : state_timer;
      motor_timer <= !spindle_accel_control ? '0 : (tick && motor_timer != '1) ?
                     motor_timer + 1'b1 : motor_timer;
    end
  end

  // Compress hold timers run while their pins are high; enable is given only in spin-up under accel control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_act_cnt <= '0;
      cmp_begin_cnt <= '0;
      compress_enable <= 1'b0;
    end else begin
      cmp_act_cnt <= !pins_sync.cmp_act ? '0 : (tick && cmp_act_cnt != '1) ?
                     cmp_act_cnt + 1'b1 : cmp_act_cnt;
      cmp_begin_cnt <= !pins_sync.cmp_begin ? '0 : (tick && cmp_begin_cnt != '1) ?
                       cmp_begin_cnt + 1'b1 : cmp_begin_cnt;
      compress_enable <= (state == ST_SPINUP) && spindle_accel_control &&
                         ((cmp_act_cnt >= TMR_WIDTH'(CMP_ACT_TICKS)) ||
                          (cmp_begin_cnt >= TMR_WIDTH'(CMP_BEGIN_TICKS)));
    end
  end

  // ==========================================================
  // Drive outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_ok <= 1'b0;
      emergency_head_retract <= 1'b1;
      actuator_lock_release <= 1'b0;
      start_winding_select <= 1'b0;
      spindle_accel_control <= 1'b0;
      spindle_accel_enable <= 1'b0;
      spindle_accel_request <= 1'b0;
      spindle_speed_ok <= 1'b0;
      start_complete <= 1'b0;
      tach_pulse <= 1'b0;
      winding_drive <= 3'h0;
      hall_fault <= 1'b0;
      initial_seek_start <= 1'b0;
      servo_reset <= 1'b0;
      drive_ready <= 1'b0;
      working <= 16'h0000;
      cyl_limit <= 10'h000;
    end else begin
      supply_ok <= supply_now;
      spindle_accel_request <= accel_req_now;
      spindle_speed_ok <= speed_good_now;
      tach_pulse <= rev_pulse[0];
      hall_fault <= spindle_accel_control & hall_bad;
      // Retract held until settings are in working memory
      emergency_head_retract <= (state == ST_POWER) || (state == ST_SUPPLY) ||
                                (state == ST_LOAD) || (state == ST_HALT);
      actuator_lock_release <= (state >= ST_UNLOCK) && (state <= ST_READY);
      if (state == ST_POWER) begin
        working <= 16'h0000;
        cyl_limit <= 10'h000;
      end else if (state == ST_LOAD) begin
        working <= nv_settings;
      end else if (state == ST_ACCEL) begin
        cyl_limit <= CYL_LIMIT_VALUE;
      end
      if (state == ST_POWER || state == ST_HALT) begin
        spindle_accel_control <= 1'b0;
        start_winding_select <= 1'b0;
      end else if (state == ST_SPINUP && !spindle_accel_control && motor_go) begin
        spindle_accel_control <= 1'b1;
        start_winding_select <= 1'b1;
      end else if (state >= ST_ACCEL && spin_main) begin
        start_winding_select <= 1'b0;
      end
      if (state == ST_POWER) begin
        start_complete <= 1'b0;
      end else if (spindle_accel_control && !accel_req_now) begin
        start_complete <= 1'b1;
      end
      // Same edge drops enable and raises start complete; start complete then holds until the power state
      spindle_accel_enable <= spindle_accel_control && accel_req_now &&
                              (state != ST_HALT);
      winding_drive <= spindle_accel_enable ? next_winding : 3'h0;
      initial_seek_start <= (next_state == ST_SEEK) && (state == ST_SETTLE);
      servo_reset <= (next_state == ST_HALT);
      drive_ready <= (next_state == ST_READY) && in_flight;
    end
  end

  // ==========================================================
  // APB slave, one wait state per access
  wire apb_access = psel & penable;
  wire apb_commit = apb_access & pready;
  wire hit_settings = (paddr == REG_SETTINGS);
  wire hit_status = (paddr == REG_STATUS);
  wire hit_period = (paddr == REG_PERIOD);
  wire hit_limit = (paddr == REG_CYL_LIMIT);
  wire hit_working = (paddr == REG_WORKING);
  wire addr_hit = hit_settings | hit_status | hit_period | hit_limit | hit_working;
  wire [31:0] status_word = {18'h00000, start_winding_select, spindle_accel_control,
                             supply_ok, hall_fault, start_complete, spindle_speed_ok,
                             drive_ready, fault, state};
  wire [31:0] rd_data = hit_settings ? {16'h0000, nv_settings} :
                        hit_status ? status_word :
                        hit_period ? {9'h000, last_period[1]} :
                        hit_limit ? {22'h000000, cyl_limit} :
                        hit_working ? {16'h0000, working} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      nv_settings <= SETTINGS_RESET;
    end else begin
      pready <= apb_access & ~pready;
      pslverr <= apb_access & ~pready & ~addr_hit;
      prdata <= (apb_access & ~pready & ~pwrite) ? rd_data : 32'h00000000;
      if (apb_commit && pwrite && hit_settings) begin
        nv_settings <= pwdata[15:0];
      end
    end
  end

endmodule

`default_nettype wire

//--- test/dpu_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dpu_sequencer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_reset_ind,
  input wire logic supply_24v_good,
  input wire logic supply_neg12v_good,
  input wire logic supply_pos12v_good,
  input wire logic supply_ok,
  input wire logic emergency_head_retract,
  input wire logic actuator_lock_release,
  input wire logic spindle_accel_control,
  input wire logic spindle_accel_enable,
  input wire logic tach_pulse,
  input wire logic [2:0] winding_drive,
  input wire logic osc_clock_out,
  input wire logic divided_clock_one,
  input wire logic initial_seek_start,
  input wire logic servo_reset,
  input wire logic drive_ready
);
  // ==========================================
  // Helpers
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire sup_all = power_on_reset_ind & supply_24v_good & supply_neg12v_good & supply_pos12v_good;
  logic seek_seen;
  // Cleared by retract so a stale seek never excuses a later ready
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) seek_seen <= 1'b0;
    else if (emergency_head_retract) seek_seen <= 1'b0;
    else if (initial_seek_start) seek_seen <= 1'b1;
  sequence s_dc1_high;
    divided_clock_one [*2] ##1 !divided_clock_one;
  endsequence
  sequence s_halted;
    servo_reset && power_on_reset_ind;
  endsequence
  // ==========================================
  // Properties
  property p_supply; (!sup_all) [*4] |-> !supply_ok; endproperty
  property p_ready; drive_ready |-> seek_seen; endproperty
  property p_seek;
    initial_seek_start |-> actuator_lock_release && !emergency_head_retract ##1
      !initial_seek_start;
  endproperty
  property p_halt;
    // Retract and motor stop follow the halt state one edge after servo reset
    servo_reset |-> !drive_ready ##1 (emergency_head_retract && !spindle_accel_control);
  endproperty
  property p_hold; s_halted |=> servo_reset; endproperty
  property p_tach; tach_pulse |=> !tach_pulse; endproperty
  property p_accel; $fell(spindle_accel_control) |=> !spindle_accel_enable; endproperty
  property p_lock; actuator_lock_release |-> !emergency_head_retract; endproperty
  property p_wind; (!spindle_accel_enable) [*2] |-> winding_drive == 3'h0; endproperty
  property p_osc; osc_clock_out |=> !osc_clock_out; endproperty
  property p_dc1; $rose(divided_clock_one) |-> s_dc1_high; endproperty
  a_supply: assert property (p_supply) else $error("supply ok while a supply is low");
  a_ready: assert property (p_ready) else $error("ready without initial seek");
  a_seek: assert property (p_seek) else $error("bad initial seek pulse");
  a_halt: assert property (p_halt) else $error("halt outputs wrong");
  a_hold: assert property (p_hold) else $error("halt left without power cycle");
  a_tach: assert property (p_tach) else $error("tach pulse too long");
  a_accel: assert property (p_accel) else $error("accel enable without control");
  a_lock: assert property (p_lock) else $error("lock released under retract");
  a_wind: assert property (p_wind) else $error("winding driven while disabled");
  a_osc: assert property (p_osc) else $error("osc clock not half rate");
  a_dc1: assert property (p_dc1) else $error("divided clock one wrong");
endmodule
bind dpu_sequencer dpu_sequencer_chk u_chk (.pclk, .presetn, .power_on_reset_ind,
  .supply_24v_good, .supply_neg12v_good, .supply_pos12v_good, .supply_ok,
  .emergency_head_retract, .actuator_lock_release, .spindle_accel_control,
  .spindle_accel_enable, .tach_pulse, .winding_drive, .osc_clock_out,
  .divided_clock_one, .initial_seek_start, .servo_reset, .drive_ready);
`default_nettype wire

//--- test/dpu_spindle_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpu_spindle_model #(
  parameter int STEP = 1822
) (
  input wire logic pclk,
  input wire logic run,
  input wire logic lock_ok,
  input wire logic actuator_lock_release,
  input wire logic spindle_accel_control,
  input wire logic initial_seek_start,
  output logic hall_phase_a_n,
  output logic hall_phase_b,
  output logic hall_phase_c_n,
  output logic actuator_unlocked_status,
  output logic seek_at_cylinder_zero
);
  // ==========================================
  // Motor, lock and seek
  int cnt = 0;
  int lk = 0;
  int sk = 0;
  logic [2:0] st = 3'h0;
  // Six steps per electrical turn, never 000 or 111
  assign hall_phase_a_n = !(st < 3'h3);
  assign hall_phase_b = st >= 3'h2 && st <= 3'h4;
  assign hall_phase_c_n = !(st >= 3'h4 || st == 3'h0);
  assign actuator_unlocked_status = lk < 20;
  assign seek_at_cylinder_zero = sk >= 30;
  always @(posedge pclk) begin
    if (run && spindle_accel_control) begin
      cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
      if (cnt == STEP - 1) st <= (st == 3'h5) ? 3'h0 : st + 3'h1;
    end
    lk <= (actuator_lock_release && lock_ok) ? lk + 1 : 0;
    if (!actuator_lock_release) sk <= 0;
    else if (initial_seek_start || (sk > 0 && sk < 30)) sk <= sk + 1;
  end
endmodule
`default_nettype wire

//--- test/tb_dpu_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dpu_sequencer;
  import dpu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 1, lock_ok = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic power_on_reset_ind = 0, supply_24v_good = 1, supply_neg12v_good = 1;
  logic supply_pos12v_good = 1, compress_active = 1, compress_begin = 0, ce_seen = 0;
  logic pready, pslverr, supply_ok, emergency_head_retract, actuator_lock_release;
  logic start_winding_select, spindle_accel_control, spindle_accel_enable, spindle_speed_ok;
  logic start_complete, compress_enable, tach_pulse, hall_fault, osc_clock_out;
  logic divided_clock_one, divided_clock_two, initial_seek_start, servo_reset, drive_ready;
  logic hall_phase_a_n, hall_phase_b, hall_phase_c_n, actuator_unlocked_status;
  logic seek_at_cylinder_zero;
  logic [2:0] winding_drive;
  logic [15:0] rs = 16'h0021;
  logic [64:0] q[$];
  logic [64:0] x;
  int n_fail = 0, checks = 0;
  dpu_sequencer #(.TICK_CYCLES(2), .SUPPLY_WAIT_TICKS(100), .SPINUP_WAIT_TICKS(40000),
    .SPEED_GOOD_WAIT_TICKS(60000), .ACCEL_END_WAIT_TICKS(500), .CMP_ACT_TICKS(50),
    .CMP_BEGIN_TICKS(60), .UNLOCK_DELAY_TICKS(50), .SEEK_WAIT_TICKS(500)) dut_u (.*);
  dpu_spindle_model model_u (.*);
  initial forever #2.5 pclk = ~pclk;
  // ==========================================
  // Tasks
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic finish_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic e);
    int k;
    k = 0;
    if (!w) q.push_back({e, m, d});
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      finish_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait: 0 ready, 1 halt, 2 motor started
  task automatic wt(input int s);
    int k;
    k = 0;
    while (k < 300000 && !(s == 0 ? drive_ready === 1'b1 : s == 1 ? servo_reset === 1'b1
        : spindle_accel_control === 1'b1)) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 300000) begin
      n_fail++;
      finish_test;
    end
    // One more edge so callers read outputs of the new state
    @(posedge pclk);
  endtask
  task automatic cyc(input logic lk, input logic [2:0] sp);
    power_on_reset_ind <= 1'b0;
    lock_ok <= lk;
    {supply_24v_good, supply_neg12v_good, supply_pos12v_good} <= sp;
    compress_begin <= lk;
    compress_active <= ~lk;
    repeat (10) @(posedge pclk);
    chk({servo_reset, emergency_head_retract}, 2'h1);
    power_on_reset_ind <= 1'b1;
  endtask
  // ==========================================
  // Read monitor and sequence
  always @(posedge pclk) begin
    if (compress_enable === 1'b1) ce_seen <= 1'b1;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      x = q.pop_front();
      chk({pslverr, prdata & x[63:32]}, {x[64], x[31:0]});
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk({emergency_head_retract, drive_ready}, 2'h2);
    apb(0, REG_SETTINGS, 32'h1, 32'hFFFF, 0);
    apb(0, REG_CYL_LIMIT, 32'h0, 32'h3FF, 0);
    apb(0, 12'h020, 32'h0, 32'hFFFFFFFF, 1);
    rs = lfsr(lfsr(rs)) | 16'h0001;
    apb(1, REG_SETTINGS, {16'h0, rs}, 0, 0);
    apb(1, REG_STATUS, {16'h0, ~rs}, 0, 0);
    apb(0, REG_SETTINGS, {16'h0, rs}, 32'hFFFF, 0);
    apb(0, REG_STATUS, 32'h0, 32'hF, 0);
    // Each supply low on its own must block supply ok
    for (int i = 0; i < 3; i++) begin
      cyc(1, ~(3'h1 << i));
      wt(1);
      chk(supply_ok, 1'b0);
      apb(0, REG_STATUS, 32'h19, 32'h7F, 0);
    end
    cyc(0, 3'h7);
    wt(1);
    chk({actuator_lock_release, ce_seen}, 2'h0);
    apb(0, REG_STATUS, 32'h29, 32'h7F, 0);
    cyc(1, 3'h7);
    wt(2);
    chk({start_winding_select, emergency_head_retract}, 2'h2);
    apb(0, REG_WORKING, {16'h0, rs}, 32'hFFFF, 0);
    wt(0);
    chk({start_winding_select, spindle_speed_ok, ce_seen, start_complete}, 4'h7);
    apb(0, REG_CYL_LIMIT, 32'h2E9, 32'h3FF, 0);
    apb(0, REG_STATUS, 32'h88, 32'hFF, 0);
    run <= 1'b0;
    wt(1);
    chk(drive_ready, 1'b0);
    apb(0, REG_STATUS, 32'h79, 32'h7F, 0);
    finish_test;
  end
endmodule
`default_nettype wire
